// file: rtl/nvsc_host.sv
// host controller driving an asynchronous nonvolatile sram
`timescale 1ns/1ps
`include "nvsc_map.svh"

module nvsc_host
	import nvsc_pkg::*;
(
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_b_i,
	// user request
	input wire logic req_i,
	input wire nvsc_op_t op_i,
	input wire nvsc_term_t term_i,
	input wire logic [`NVSC_ADDR_W-1:0] addr_i,
	input wire logic [`NVSC_DATA_W-1:0] wdata_i,
	input wire logic [1:0] lanes_i,
	input wire logic [`NVSC_ADDR_W*`NVSC_CMD_LEN-1:0] cmd_seq_i,
	input wire logic powerup_i,
	output logic ready_o,
	output logic done_o,
	output logic [`NVSC_DATA_W-1:0] rdata_o,
	output logic timeout_o,
	// memory pins
	output logic [`NVSC_ADDR_W-1:0] mem_addr_o,
	output logic chip_sel_n_o,
	output logic write_n_o,
	output logic out_gate_n_o,
	output logic low_byte_lane_n_o,
	output logic high_byte_lane_n_o,
	input wire logic [`NVSC_DATA_W-1:0] mem_dq_i,
	output logic [`NVSC_DATA_W-1:0] mem_dq_o,
	output logic mem_dq_oe_o,
	// store busy pin, open drain
	input wire logic store_busy_n_i,
	output logic store_busy_n_o,
	output logic store_busy_n_oe_o
);

	//------------------------------------------------------------
	// reset and pin synchronisers
	//------------------------------------------------------------
	logic [1:0] rst_sync_q;
	logic rst_n;
	logic [2:0] busy_sync_q;
	logic busy_low_q;

	// release through two flops
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rst_sync_q <= 2'h0;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_q[1];

	// three flops; a change counts when stages two and three agree
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			busy_sync_q <= 3'h7;
			busy_low_q <= 1'b0;
		end else begin
			busy_sync_q <= {busy_sync_q[1:0], store_busy_n_i};
			if (busy_sync_q[2] == busy_sync_q[1]) begin
				busy_low_q <= ~busy_sync_q[2];
			end
		end
	end

	//------------------------------------------------------------
	// sequencer
	//------------------------------------------------------------
	typedef enum logic [3:0] {
		ST_PWRUP, ST_IDLE, ST_SETUP, ST_STROBE, ST_RECOVER,
		ST_SAVE_PULSE, ST_GRACE, ST_BUSY
	} nvsc_state_t;

	nvsc_state_t state_q;
	nvsc_op_t op_q;
	nvsc_term_t term_q;
	logic [`NVSC_TMR_W-1:0] tmr_q;
	logic [`NVSC_TMR_W-1:0] limit_q;
	logic [2:0] step_q;
	logic [`NVSC_ADDR_W-1:0] addr_q;
	logic [`NVSC_ADDR_W*`NVSC_CMD_LEN-1:0] seq_q;
	logic is_read;

	assign is_read = (op_q == NVSC_OP_READ) || (op_q == NVSC_OP_CMD);

	// state, timer and sequence step
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= ST_PWRUP;
			op_q <= NVSC_OP_READ;
			term_q <= NVSC_TERM_CS;
			tmr_q <= '0;
			limit_q <= `NVSC_TMR_W'(`NVSC_T_PWRUP_CLK);
			step_q <= 3'h0;
			addr_q <= '0;
			seq_q <= '0;
		end else begin
			tmr_q <= tmr_q + `NVSC_TMR_W'(1);
			unique case (state_q)
				ST_PWRUP: begin
					// wait out power-up restore, ends early when busy released
					if (powerup_i || (tmr_q >= limit_q) ||
						(tmr_q > `NVSC_TMR_W'(`NVSC_T_GRACE_CLK) && !busy_low_q)) begin
						state_q <= ST_IDLE;
					end
				end
				ST_IDLE: begin
					tmr_q <= '0;
					if (req_i && !busy_low_q) begin
						op_q <= op_i;
						term_q <= (op_i == NVSC_OP_CMD) ? NVSC_TERM_CS : term_i;
						addr_q <= (op_i == NVSC_OP_CMD) ? cmd_seq_i[`NVSC_ADDR_W-1:0] : addr_i;
						seq_q <= cmd_seq_i;
						step_q <= 3'h0;
						state_q <= (op_i == NVSC_OP_SAVE) ? ST_SAVE_PULSE : ST_SETUP;
					end
				end
				ST_SETUP: begin
					// address and lanes settle with strobes high
					tmr_q <= '0;
					state_q <= ST_STROBE;
				end
				ST_STROBE: begin
					if (tmr_q >= `NVSC_TMR_W'(`NVSC_T_PULSE_CLK)) begin
						tmr_q <= '0;
						state_q <= ST_RECOVER;
					end
				end
				ST_RECOVER: begin
					if (tmr_q >= `NVSC_TMR_W'(`NVSC_T_CYC_CLK - `NVSC_T_PULSE_CLK)) begin
						if (op_q == NVSC_OP_CMD && step_q != 3'(`NVSC_CMD_LEN - 1)) begin
							// next command address back to back
							step_q <= step_q + 3'h1;
							addr_q <= seq_q[(32'(step_q) + 1) * `NVSC_ADDR_W +: `NVSC_ADDR_W];
							state_q <= ST_SETUP;
						end else if (op_q == NVSC_OP_CMD) begin
							tmr_q <= '0;
							limit_q <= `NVSC_TMR_W'(`NVSC_T_SSP_CLK + `NVSC_T_STORE_CLK);
							state_q <= ST_GRACE;
						end else begin
							state_q <= ST_IDLE;
						end
					end
				end
				ST_SAVE_PULSE: begin
					if (tmr_q >= `NVSC_TMR_W'(`NVSC_T_SAVE_REQ_CLK - 1)) begin
						tmr_q <= '0;
						limit_q <= `NVSC_TMR_W'(`NVSC_T_STORE_CLK);
						state_q <= ST_GRACE;
					end
				end
				ST_GRACE: begin
					// busy may not show yet; a skipped save never shows it
					if (busy_low_q) begin
						state_q <= ST_BUSY;
					end else if (tmr_q >= `NVSC_TMR_W'(`NVSC_T_GRACE_CLK + 3)) begin
						state_q <= ST_IDLE;
					end
				end
				ST_BUSY: begin
					// hold off all access until the device lets go
					if (!busy_low_q || tmr_q >= limit_q) begin
						state_q <= ST_IDLE;
					end
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	//------------------------------------------------------------
	// memory pins, registered
	//------------------------------------------------------------
	logic in_cycle;
	logic strobe;
	logic lane_on;
	assign in_cycle = (state_q == ST_SETUP) || (state_q == ST_STROBE);
	assign strobe = (state_q == ST_STROBE);
	// lanes lead select and strobe and hold until both are released, so a lane never ends a write
	assign lane_on = in_cycle || (state_q == ST_RECOVER);

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			mem_addr_o <= '0;
			chip_sel_n_o <= 1'b1;
			write_n_o <= 1'b1;
			out_gate_n_o <= 1'b1;
			low_byte_lane_n_o <= 1'b1;
			high_byte_lane_n_o <= 1'b1;
			mem_dq_o <= '0;
			mem_dq_oe_o <= 1'b0;
		end else begin
			mem_addr_o <= addr_q;
			// lanes come up with the setup cycle, before select or strobe
			low_byte_lane_n_o <= !(lane_on && (lanes_i[0] || op_q == NVSC_OP_CMD));
			high_byte_lane_n_o <= !(lane_on && (lanes_i[1] || op_q == NVSC_OP_CMD));
			// select ends the cycle unless strobe or gate is chosen; then select outlasts them
			chip_sel_n_o <= !(strobe || (state_q == ST_RECOVER && term_q != NVSC_TERM_CS));
			write_n_o <= !(strobe && !is_read);
			out_gate_n_o <= !(is_read && (strobe || (in_cycle && term_q != NVSC_TERM_OE)));
			mem_dq_o <= wdata_i;
			mem_dq_oe_o <= strobe && !is_read;
		end
	end

	//------------------------------------------------------------
	// store busy pin: released unless a save is requested
	//------------------------------------------------------------
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			store_busy_n_o <= 1'b1;
			store_busy_n_oe_o <= 1'b0;
		end else begin
			store_busy_n_o <= 1'b0;
			store_busy_n_oe_o <= (state_q == ST_SAVE_PULSE);
		end
	end

	//------------------------------------------------------------
	// user side status
	//------------------------------------------------------------
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			ready_o <= 1'b0;
			done_o <= 1'b0;
			rdata_o <= '0;
			timeout_o <= 1'b0;
		end else begin
			ready_o <= (state_q == ST_IDLE) && !busy_low_q;
			done_o <= 1'b0;
			timeout_o <= 1'b0;
			// sample data at end of strobe, plain reads only; command reads are not trusted
			if (state_q == ST_STROBE && tmr_q >= `NVSC_TMR_W'(`NVSC_T_PULSE_CLK) &&
				op_q == NVSC_OP_READ) begin
				rdata_o <= mem_dq_i;
			end
			if ((state_q == ST_RECOVER && op_q != NVSC_OP_CMD &&
				tmr_q >= `NVSC_TMR_W'(`NVSC_T_CYC_CLK - `NVSC_T_PULSE_CLK)) ||
				(state_q == ST_GRACE && !busy_low_q &&
				tmr_q >= `NVSC_TMR_W'(`NVSC_T_GRACE_CLK + 3)) ||
				(state_q == ST_BUSY && (!busy_low_q || tmr_q >= limit_q))) begin
				done_o <= 1'b1;
			end
			if (state_q == ST_BUSY && busy_low_q && tmr_q >= limit_q) begin
				timeout_o <= 1'b1;
			end
		end
	end

endmodule : nvsc_host

// file: rtl/nvsc_map.svh
// constants for the nonvolatile sram host controller
//------------------------------------------------------------
// Notes on behaviour
// - write strobe stays high through every read cycle.
// - store_busy_n is left released during ordinary reads and writes.
// - clock register writes end by select or strobe, never byte lanes.
// - low byte lane is asserted before select or strobe for clock writes.
// - command sequence advances on select or gate terminated reads.
// - six command addresses are read in order, strobe high throughout.
// - pin-triggered save request drives store_busy_n low 15 ns or more.
//------------------------------------------------------------
`ifndef NVSC_MAP_SVH
`define NVSC_MAP_SVH

`define NVSC_CLK_MHZ 100
`define NVSC_ADDR_W 18
`define NVSC_DATA_W 16
`define NVSC_CMD_LSB 2
`define NVSC_CMD_MSB 14
`define NVSC_CMD_LEN 6
// memory cycle timing in ns
`define NVSC_T_CYC_NS 25
`define NVSC_T_PULSE_NS 20
`define NVSC_T_CYC_CLK ((`NVSC_T_CYC_NS * `NVSC_CLK_MHZ + 999) / 1000)
`define NVSC_T_PULSE_CLK ((`NVSC_T_PULSE_NS * `NVSC_CLK_MHZ + 999) / 1000)
// pin-triggered save pulse
`define NVSC_T_SAVE_REQ_NS 15
`define NVSC_T_SAVE_REQ_CLK ((`NVSC_T_SAVE_REQ_NS * `NVSC_CLK_MHZ + 999) / 1000)
// wait for busy to appear after a request or a command
`define NVSC_T_GRACE_NS 25
`define NVSC_T_GRACE_CLK ((`NVSC_T_GRACE_NS * `NVSC_CLK_MHZ + 999) / 1000)
// longest operations in us and ms
`define NVSC_T_SSP_US 100
`define NVSC_T_RECALL_US 200
`define NVSC_T_STORE_MS 8
`define NVSC_T_PWRUP_MS 20
`define NVSC_T_SSP_CLK (`NVSC_T_SSP_US * `NVSC_CLK_MHZ)
`define NVSC_T_RECALL_CLK (`NVSC_T_RECALL_US * `NVSC_CLK_MHZ)
`define NVSC_T_STORE_CLK (`NVSC_T_STORE_MS * 1000 * `NVSC_CLK_MHZ)
`define NVSC_T_PWRUP_CLK (`NVSC_T_PWRUP_MS * 1000 * `NVSC_CLK_MHZ)
`define NVSC_TMR_W 22

`endif

// file: rtl/nvsc_pkg.sv
// types for the nonvolatile sram host controller
package nvsc_pkg;

	typedef enum logic [1:0] {
		NVSC_OP_READ,
		NVSC_OP_WRITE,
		NVSC_OP_CMD,
		NVSC_OP_SAVE
	} nvsc_op_t;

	typedef enum logic [1:0] {
		NVSC_TERM_CS,
		NVSC_TERM_WE,
		NVSC_TERM_OE
	} nvsc_term_t;

endpackage : nvsc_pkg

// file: testbench/nvsc_dev_model.sv
// behavioural nonvolatile sram seen from its pins
`timescale 1ns/1ps

module nvsc_dev_model #(
	parameter int RST_T = 40,
	parameter int SAVE_T = 60,
	parameter int SW_T = 30,
	parameter logic [77:0] SEQ = '0
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_b_i,
	// memory pins
	input wire logic [17:0] addr_i,
	input wire logic chip_sel_n_i,
	input wire logic write_n_i,
	input wire logic out_gate_n_i,
	input wire logic low_byte_lane_n_i,
	input wire logic high_byte_lane_n_i,
	input wire logic [15:0] dq_i,
	output logic [15:0] dq_o,
	// busy pin and counts
	input wire logic busy_n_i,
	output logic busy_drv_o,
	output logic busy_val_o,
	output int saves_o,
	output int cmds_o
);
	logic [15:0] mem [256];
	logic [15:0] last_q;
	logic [12:0] cmd_q;
	logic [2:0] idx_q;
	logic pend_q, hiz_q, rd_q, cs_q;
	int busy_q, hold_q, grace_q, lo_q;
	wire rd = !chip_sel_n_i && !out_gate_n_i && write_n_i;
	wire blk = busy_q > 0 && grace_q == 0;
	assign busy_drv_o = busy_q > 0 || hold_q > 0;
	assign busy_val_o = busy_q == 0;
	// floating lines show a pattern that flips every cycle
	assign dq_o = (rd && !blk && !hiz_q) ? mem[addr_i[7:0]] : ~last_q;
	// edge tracking and command address capture
	always_ff @(posedge clk_i) begin
		cs_q <= chip_sel_n_i;
		rd_q <= rd;
		last_q <= dq_o;
		if (rd) cmd_q <= addr_i[14:2];
		if (chip_sel_n_i) hiz_q <= 1'b0;
		else if (cs_q && !write_n_i) hiz_q <= 1'b1;
	end
	// writes, saves, restores and the command matcher
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			busy_q <= RST_T;
			hold_q <= 0;
			grace_q <= 0;
			lo_q <= 0;
			pend_q <= 1'b0;
			idx_q <= 3'h0;
			saves_o <= 0;
			cmds_o <= 0;
		end else begin
			lo_q <= (!busy_n_i && !busy_drv_o) ? lo_q + 1 : 0;
			if (grace_q > 0) grace_q <= grace_q - 1;
			if (hold_q > 0) hold_q <= hold_q - 1;
			if (!chip_sel_n_i && !write_n_i && !blk) begin
				pend_q <= 1'b1;
				if (!low_byte_lane_n_i) mem[addr_i[7:0]][7:0] <= dq_i[7:0];
				if (!high_byte_lane_n_i) mem[addr_i[7:0]][15:8] <= dq_i[15:8];
			end
			if (busy_q > 0) begin
				busy_q <= busy_q - 1;
				if (busy_q == 1) hold_q <= 3;
				if (busy_q == 1) pend_q <= 1'b0;
			end else if (lo_q == 1 && !busy_n_i && pend_q) begin
				busy_q <= SAVE_T;
				grace_q <= 3;
				saves_o <= saves_o + 1;
			end else if (rd_q && !rd) begin
				if (cmd_q != SEQ[idx_q*13+:13]) idx_q <= (cmd_q == SEQ[12:0]) ? 3'h1 : 3'h0;
				else if (idx_q != 3'h5) idx_q <= idx_q + 3'h1;
				else begin
					idx_q <= 3'h0;
					busy_q <= SW_T;
					cmds_o <= cmds_o + 1;
				end
			end
		end
	end
endmodule : nvsc_dev_model

// file: testbench/nvsc_host_sva.sv
// pin-order checks for the nonvolatile sram host controller
`timescale 1ns/1ps
`include "nvsc_map.svh"

module nvsc_host_sva
	import nvsc_pkg::*;
(
	// clock, reset and request
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic req_i,
	input wire nvsc_op_t op_i,
	input wire logic [`NVSC_ADDR_W*`NVSC_CMD_LEN-1:0] cmd_seq_i,
	input wire logic ready_o,
	// memory pins
	input wire logic [`NVSC_ADDR_W-1:0] mem_addr_o,
	input wire logic chip_sel_n_o,
	input wire logic write_n_o,
	input wire logic out_gate_n_o,
	input wire logic low_byte_lane_n_o,
	input wire logic high_byte_lane_n_o,
	input wire logic store_busy_n_o,
	input wire logic store_busy_n_oe_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);
	// a read must never see the strobe low
	a_read_strobe_high: assert property (!chip_sel_n_o && !out_gate_n_o |-> write_n_o)
		else $error("write strobe low during a read");
	a_busy_left_free: assert property (!chip_sel_n_o |-> !store_busy_n_oe_o)
		else $error("busy pin pulled during a memory cycle");
	a_busy_pull_low: assert property (store_busy_n_oe_o |-> !store_busy_n_o)
		else $error("busy pin driven high");
	a_save_pulse_len: assert property ($rose(store_busy_n_oe_o) |=> store_busy_n_oe_o)
		else $error("save request pulse too short");
	// lanes must not be what ends a write
	a_lane_no_end: assert property ($rose(low_byte_lane_n_o) || $rose(high_byte_lane_n_o)
		|-> write_n_o || chip_sel_n_o) else $error("write ended by a byte lane");
	a_lane_first: assert property ($fell(chip_sel_n_o) || $fell(write_n_o)
		|-> !$fell(low_byte_lane_n_o)) else $error("low lane not ahead of strobe");
	a_cmd_first_addr: assert property (ready_o && req_i && op_i == NVSC_OP_CMD |->
		##[1:12] ($fell(chip_sel_n_o) && mem_addr_o == cmd_seq_i[`NVSC_ADDR_W-1:0]))
		else $error("command sequence does not open with its first address");
	c_save: cover property ($rose(store_busy_n_oe_o));
	c_cmd: cover property (ready_o && req_i && op_i == NVSC_OP_CMD);
	c_write: cover property ($fell(write_n_o));
endmodule : nvsc_host_sva

bind nvsc_host nvsc_host_sva u_sva (.clk_i, .rst_b_i, .req_i, .op_i, .cmd_seq_i, .ready_o,
	.mem_addr_o, .chip_sel_n_o, .write_n_o, .out_gate_n_o, .low_byte_lane_n_o,
	.high_byte_lane_n_o, .store_busy_n_o, .store_busy_n_oe_o);

// file: testbench/tb_top.sv
// self-checking bench for the nonvolatile sram host controller
`timescale 1ns/1ps
`include "nvsc_map.svh"
`define NVSC_CHK(what, exp, got) begin n_checks++; if ((got) !== (exp)) begin failures++; \
	$display("wrong value %s expected %h seen %h", what, exp, got); end end

module tb_top;
	import nvsc_pkg::*;
	localparam int RST_T = 40;
	localparam int SAVE_T = 60;
	localparam logic [77:0] SEQ = {13'h03f1, 13'h1c0f, 13'h01f0, 13'h03e0, 13'h01c7, 13'h0e38};
	logic clk_i, rst_b_i, req_i, powerup_i, ready_o, done_o, timeout_o;
	nvsc_op_t op_i;
	nvsc_term_t term_i;
	logic [17:0] addr_i, mem_addr_o;
	logic [15:0] wdata_i, rdata_o, mem_dq_o, dev_dq, mem_dq_i;
	logic [1:0] lanes_i;
	logic [107:0] cmd_seq_i;
	logic chip_sel_n_o, write_n_o, out_gate_n_o, low_byte_lane_n_o, high_byte_lane_n_o;
	logic mem_dq_oe_o, store_busy_n_i, store_busy_n_o, store_busy_n_oe_o, dev_drv, dev_val;
	int failures = 0, n_checks = 0, cycles = 0, saves, cmds;
	// open-drain busy wire with a pull-up
	assign store_busy_n_i = store_busy_n_oe_o ? store_busy_n_o : (dev_drv ? dev_val : 1'b1);
	assign mem_dq_i = mem_dq_oe_o ? mem_dq_o : dev_dq;
	nvsc_host dut_u (.clk_i, .rst_b_i, .req_i, .op_i, .term_i, .addr_i, .wdata_i, .lanes_i,
		.cmd_seq_i, .powerup_i, .ready_o, .done_o, .rdata_o, .timeout_o, .mem_addr_o,
		.chip_sel_n_o, .write_n_o, .out_gate_n_o, .low_byte_lane_n_o, .high_byte_lane_n_o,
		.mem_dq_i, .mem_dq_o, .mem_dq_oe_o, .store_busy_n_i, .store_busy_n_o, .store_busy_n_oe_o);
	nvsc_dev_model #(.RST_T(RST_T), .SAVE_T(SAVE_T), .SEQ(SEQ)) dev_u (.clk_i, .rst_b_i,
		.addr_i(mem_addr_o), .chip_sel_n_i(chip_sel_n_o), .write_n_i(write_n_o),
		.out_gate_n_i(out_gate_n_o), .low_byte_lane_n_i(low_byte_lane_n_o),
		.high_byte_lane_n_i(high_byte_lane_n_o), .dq_i(mem_dq_i), .dq_o(dev_dq),
		.busy_n_i(store_busy_n_i), .busy_drv_o(dev_drv), .busy_val_o(dev_val),
		.saves_o(saves), .cmds_o(cmds));
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	// hang guard, well above the few hundred cycles the tests need
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 20000) begin
			failures++;
			summarize();
		end
	end
	task automatic summarize();
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : summarize
	// one operation, cyc counts edges from take to done
	task automatic run_op(input nvsc_op_t op, input nvsc_term_t tm, input logic [17:0] a,
		input logic [15:0] d, input logic [1:0] ln, output int cyc);
		while (ready_o !== 1'b1) @(negedge clk_i);
		req_i = 1'b1;
		op_i = op;
		term_i = tm;
		{addr_i, wdata_i, lanes_i} = {a, d, ln};
		@(negedge clk_i);
		req_i = 1'b0;
		cyc = 0;
		while (done_o !== 1'b1) begin
			@(negedge clk_i);
			cyc++;
		end
		`NVSC_CHK("timeout", 1'b0, timeout_o)
	endtask : run_op
	task automatic t_rdwr();
		int c;
		while (ready_o !== 1'b1) @(negedge clk_i);
		`NVSC_CHK("restore wait", 1'b1, cycles >= RST_T)
		run_op(NVSC_OP_WRITE, NVSC_TERM_CS, 18'h00012, 16'ha55a, 2'h3, c);
		run_op(NVSC_OP_WRITE, NVSC_TERM_WE, 18'h00034, 16'h1234, 2'h1, c);
		run_op(NVSC_OP_WRITE, NVSC_TERM_OE, 18'h00034, 16'hbeef, 2'h2, c);
		run_op(NVSC_OP_READ, NVSC_TERM_OE, 18'h00012, 16'h0000, 2'h3, c);
		`NVSC_CHK("read full", 16'ha55a, rdata_o)
		run_op(NVSC_OP_READ, NVSC_TERM_CS, 18'h00034, 16'h0000, 2'h3, c);
		`NVSC_CHK("read lanes", 16'hbe34, rdata_o)
		$display("test rdwr done");
	endtask : t_rdwr
	task automatic t_save();
		int c, s0;
		s0 = saves;
		run_op(NVSC_OP_SAVE, NVSC_TERM_CS, 18'h0, 16'h0, 2'h0, c);
		`NVSC_CHK("save taken", s0 + 1, saves)
		`NVSC_CHK("save waited", 1'b1, c >= SAVE_T)
		run_op(NVSC_OP_SAVE, NVSC_TERM_CS, 18'h0, 16'h0, 2'h0, c);
		`NVSC_CHK("clean save", s0 + 1, saves)
		run_op(NVSC_OP_READ, NVSC_TERM_CS, 18'h00012, 16'h0000, 2'h3, c);
		`NVSC_CHK("read after save", 16'ha55a, rdata_o)
		$display("test save done");
	endtask : t_save
	// flip alters every address; bit 15 is outside the matched field
	task automatic t_cmd(input logic [17:0] flip, input int inc);
		int c, c0, k;
		c0 = cmds;
		for (k = 0; k < 6; k++) cmd_seq_i[k*18+:18] = {3'h0, SEQ[k*13+:13], 2'h0} ^ flip;
		run_op(NVSC_OP_CMD, NVSC_TERM_CS, 18'h0, 16'h0, 2'h3, c);
		`NVSC_CHK("command seen", c0 + inc, cmds)
		$display("test cmd done");
	endtask : t_cmd
	initial begin
		{rst_b_i, req_i, powerup_i, addr_i, wdata_i, lanes_i, cmd_seq_i} = '0;
		op_i = NVSC_OP_READ;
		term_i = NVSC_TERM_CS;
		repeat (10) @(negedge clk_i);
		rst_b_i = 1'b1;
		t_rdwr();
		t_save();
		t_cmd(18'h00000, 1);
		t_cmd(18'h08000, 1);
		t_cmd(18'h00004, 0);
		summarize();
	end
endmodule : tb_top
